// File: shared/hpm_pkg.sv
// Constants and types shared by the high-product multiply unit
`default_nettype none
package hpm_pkg;
   localparam int unsigned XLEN = 64;
   localparam int unsigned WLEN = 32;
   localparam logic [5:0] HPM_PRIMARY_OP = 6'h1f;
   localparam logic [8:0] HPM_XOP_HI_DWORD_S = 9'h049;
   localparam logic [8:0] HPM_XOP_HI_DWORD_U = 9'h009;
   localparam logic [8:0] HPM_XOP_HI_WORD_S = 9'h04b;
   localparam logic [8:0] HPM_XOP_WORD_LEGACY = 9'h06b;
   // Instruction field positions, bit 0 is the least significant bit
   localparam int unsigned HPM_POS_PRIMARY_HI = 31;
   localparam int unsigned HPM_POS_PRIMARY_LO = 26;
   localparam int unsigned HPM_POS_TARGET_HI = 25;
   localparam int unsigned HPM_POS_TARGET_LO = 21;
   localparam int unsigned HPM_POS_XOP_HI = 9;
   localparam int unsigned HPM_POS_XOP_LO = 1;
   localparam int unsigned HPM_POS_OE = 10;
   localparam int unsigned HPM_POS_RECORD = 0;
   // Exception register bit positions in a 32-bit word
   localparam int unsigned HPM_XER_SUMMARY = 31;
   localparam int unsigned HPM_XER_EXCESS = 30;
   // Condition field bit positions
   localparam int unsigned HPM_CF_NEG = 3;
   localparam int unsigned HPM_CF_POS = 2;
   localparam int unsigned HPM_CF_ZERO = 1;
   localparam int unsigned HPM_CF_SUMMARY = 0;
   localparam logic [63:0] HPM_RESET_DWORD = 64'h0000_0000_0000_0000;
   localparam logic [31:0] HPM_RESET_WORD = 32'h0000_0000;
   localparam logic [3:0] HPM_RESET_FIELD = 4'h0;
   typedef enum logic [2:0]
   {
      HPM_OP_NONE = 3'h0,
      HPM_OP_HD_S = 3'h1,
      HPM_OP_HD_U = 3'h3,
      HPM_OP_HW_S = 3'h2,
      HPM_OP_W_LEG = 3'h6,
      HPM_OP_ILLEGAL = 3'h7
   } hpm_op_e;
endpackage
`default_nettype wire

// File: shared/hpm_dec_if.sv
// Decoded operation handed from the decoder to the datapath
`timescale 1ns/1ps
`default_nettype none
interface hpm_dec_if;
   import hpm_pkg::*;
   hpm_op_e op;
   logic record_bit;
   logic oe_bit;
   logic [4:0] target_register;
   modport dec
   (
      output op,
      output record_bit,
      output oe_bit,
      output target_register
   );
   modport dp
   (
      input op,
      input record_bit,
      input oe_bit,
      input target_register
   );
endinterface
`default_nettype wire

// File: core/hpm_decode.sv
// Combinational instruction decoder of the high-product multiply unit
`timescale 1ns/1ps
`default_nettype none
module hpm_decode
   import hpm_pkg::*;
(
   input wire logic [31:0] instr_i,
   input wire logic is_64bit_i,
   hpm_dec_if.dec dec
);
   logic [5:0] primary;
   logic [8:0] xop;
   logic bit21;

   assign primary = instr_i[HPM_POS_PRIMARY_HI:HPM_POS_PRIMARY_LO];
   assign xop = instr_i[HPM_POS_XOP_HI:HPM_POS_XOP_LO];
   assign bit21 = instr_i[HPM_POS_OE];
   assign dec.record_bit = instr_i[HPM_POS_RECORD];
   assign dec.oe_bit = bit21;
   assign dec.target_register = instr_i[HPM_POS_TARGET_HI:HPM_POS_TARGET_LO];

   always_comb
   begin
      dec.op = HPM_OP_NONE;
      if (primary == HPM_PRIMARY_OP)
      begin
         // [RL1] signed doubleword decode
         if (xop == HPM_XOP_HI_DWORD_S && !bit21)
         begin
            // [RL3] narrow core traps
            dec.op = is_64bit_i ? HPM_OP_HD_S : HPM_OP_ILLEGAL;
         end
         // [RL4] unsigned doubleword decode
         else if (xop == HPM_XOP_HI_DWORD_U && !bit21)
         begin
            // [RL3] narrow core traps
            dec.op = is_64bit_i ? HPM_OP_HD_U : HPM_OP_ILLEGAL;
         end
         // [RL8] high word decode
         else if (xop == HPM_XOP_HI_WORD_S)
         begin
            dec.op = HPM_OP_HW_S;
         end
         else if (xop == HPM_XOP_WORD_LEGACY)
         begin
            dec.op = HPM_OP_W_LEG;
         end
      end
   end
endmodule
`default_nettype wire

// File: core/hpm_unit.sv
// High-product multiply datapath with one-cycle registered result
//
// How it works
// [RL1] Signed high doubleword: opcode 31, extended 73, bit 21 zero.
// [RL2] Signed 128-bit product; upper 64 bits go to target.
// [RL3] Doubleword forms on a 32-bit core raise illegal instruction.
// [RL4] Unsigned high doubleword: opcode 31, extended 9, bit 21 zero.
// [RL5] Unsigned 128-bit product; upper 64 bits go to target.
// [RL6] Unsigned form sets condition flags by signed compare with zero.
// [RL7] Unsigned form updates condition field only with record bit set.
// [RL8] Signed high word: opcode 31, extended 75.
// [RL9] Signed 64-bit word product; upper 32 bits go to target.
// [RL10] High word: flags from result, summary copied, only with record.
// [RL11] Legacy word multiply writes target and extension register.
// [RL12] Legacy overflow form sets summary and excess on 32-bit overflow.
// [RL13] High product half to target, low half to extension.
// [RL14] Legacy record flags follow the extension word.
// [RL15] Signed doubleword record sets flags, copies summary.
// [RL16] High-product forms leave exception register unchanged.
`timescale 1ns/1ps
`default_nettype none
module hpm_unit
   import hpm_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic issue_i,
   input wire logic [31:0] instr_i,
   input wire logic is_64bit_i,
   input wire logic [63:0] first_source_register_i,
   input wire logic [63:0] second_source_register_i,
   input wire logic [31:0] fixed_point_exception_register_i,
   output logic done_o,
   output logic illegal_o,
   output logic [4:0] target_index_o,
   output logic [63:0] target_register_o,
   output logic target_write_o,
   output logic [3:0] condition_field_zero_o,
   output logic condition_write_o,
   output logic [31:0] fixed_point_exception_register_o,
   output logic exception_write_o,
   output logic [31:0] product_extension_register_o
);
   hpm_dec_if dec_bus ();

   hpm_decode u_decode
   (
      .instr_i(instr_i),
      .is_64bit_i(is_64bit_i),
      .dec(dec_bus.dec)
   );

   logic [127:0] prod_s;
   logic [127:0] prod_u;
   logic [63:0] prod_w;
   logic [63:0] result_next;
   logic [31:0] ext_next;
   logic ext_wr_next;
   logic [63:0] flag_src;
   logic summary_in;
   logic [3:0] field_next;
   logic cf_wr_next;
   logic xer_wr_next;
   logic [31:0] xer_next;
   logic word_over;
   logic legal;

   // [RL2] signed wide product
   assign prod_s = 128'($signed(first_source_register_i)
                   * $signed(second_source_register_i));
   // [RL5] unsigned wide product
   assign prod_u = first_source_register_i * second_source_register_i;
   // [RL9] signed word product
   assign prod_w = 64'($signed(first_source_register_i[31:0])
                   * $signed(second_source_register_i[31:0]));
   assign word_over = (prod_w[63:32] != {32{prod_w[31]}});
   assign summary_in = fixed_point_exception_register_i[HPM_XER_SUMMARY];
   assign legal = issue_i && dec_bus.op != HPM_OP_NONE
                  && dec_bus.op != HPM_OP_ILLEGAL;

   always_comb
   begin
      result_next = HPM_RESET_DWORD;
      ext_next = product_extension_register_o;
      ext_wr_next = 1'b0;
      flag_src = HPM_RESET_DWORD;
      xer_next = fixed_point_exception_register_i;
      xer_wr_next = 1'b0;
      unique case (dec_bus.op)
         HPM_OP_HD_S:
         begin
            result_next = prod_s[127:64];
            flag_src = prod_s[127:64];
         end
         HPM_OP_HD_U:
         begin
            result_next = prod_u[127:64];
            flag_src = prod_u[127:64];
         end
         HPM_OP_HW_S:
         begin
            result_next = {{32{prod_w[63]}}, prod_w[63:32]};
            flag_src = {{32{prod_w[63]}}, prod_w[63:32]};
         end
         HPM_OP_W_LEG:
         begin
            // [RL13] halves split: upper half to target, lower to extension
            result_next = {32'h0000_0000, prod_w[63:32]};
            // [RL11] extension register written
            ext_next = prod_w[31:0];
            ext_wr_next = 1'b1;
            // [RL14] flags from extension word
            flag_src = {{32{prod_w[31]}}, prod_w[31:0]};
            // [RL12] overflow sets summary and excess
            if (dec_bus.oe_bit && word_over)
            begin
               xer_next[HPM_XER_SUMMARY] = 1'b1;
               xer_next[HPM_XER_EXCESS] = 1'b1;
            end
            xer_wr_next = dec_bus.oe_bit;
         end
         default:
         begin
            result_next = HPM_RESET_DWORD;
         end
      endcase
   end

   always_comb
   begin
      // [RL6] signed compare with zero
      field_next[HPM_CF_NEG] = flag_src[63];
      field_next[HPM_CF_POS] = !flag_src[63] && (flag_src != 64'h0);
      field_next[HPM_CF_ZERO] = (flag_src == 64'h0);
      // [RL15] summary copied
      field_next[HPM_CF_SUMMARY] = summary_in
         || (xer_wr_next && xer_next[HPM_XER_SUMMARY]);
      // [RL7] record bit gates update
      cf_wr_next = legal && dec_bus.record_bit;
   end

   // Issue handshake and trap
   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         done_o <= 1'b0;
         illegal_o <= 1'b0;
         target_write_o <= 1'b0;
         target_index_o <= 5'h00;
      end
      else
      begin
         done_o <= legal;
         // [RL3] illegal on narrow core
         illegal_o <= issue_i && dec_bus.op == HPM_OP_ILLEGAL;
         target_write_o <= legal;
         target_index_o <= dec_bus.target_register;
      end
   end

   // Result datapath
   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         target_register_o <= HPM_RESET_DWORD;
      end
      else if (legal)
      begin
         target_register_o <= result_next;
      end
   end

   // Condition field
   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         condition_field_zero_o <= HPM_RESET_FIELD;
         condition_write_o <= 1'b0;
      end
      else
      begin
         condition_write_o <= cf_wr_next;
         // [RL10] untouched when record clear
         if (cf_wr_next)
         begin
            condition_field_zero_o <= field_next;
         end
      end
   end

   // Exception register and extension register
   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
      begin
         fixed_point_exception_register_o <= HPM_RESET_WORD;
         exception_write_o <= 1'b0;
         product_extension_register_o <= HPM_RESET_WORD;
      end
      else
      begin
         // [RL16] only legacy overflow form writes
         exception_write_o <= legal && xer_wr_next;
         if (legal && xer_wr_next)
         begin
            fixed_point_exception_register_o <= xer_next;
         end
         if (legal && ext_wr_next)
         begin
            product_extension_register_o <= ext_next;
         end
      end
   end

   sequence issue_hd_s;
      issue_i && dec_bus.op == HPM_OP_HD_S;
   endsequence

   sequence issue_hi_any;
      issue_i && (dec_bus.op == HPM_OP_HD_S || dec_bus.op == HPM_OP_HD_U
                  || dec_bus.op == HPM_OP_HW_S);
   endsequence

   hd_signed_a: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
      issue_hd_s |=> target_register_o == $past(prod_s[127:64])) // [RL2]
      else $error("signed doubleword high result wrong");
   hd_unsigned_a: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i) // [RL5]
      issue_i && dec_bus.op == HPM_OP_HD_U
      |=> target_register_o == $past(prod_u[127:64]))
      else $error("unsigned doubleword high result wrong");
   narrow_trap_a: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i) // [RL3]
      issue_i && !is_64bit_i && dec_bus.op inside {HPM_OP_ILLEGAL}
      |=> illegal_o && !target_write_o)
      else $error("doubleword on narrow core not trapped");
   record_gate_a: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i) // [RL7]
      issue_i && !dec_bus.record_bit
      |=> !condition_write_o && $stable(condition_field_zero_o))
      else $error("condition field written without record bit");
   word_high_a: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i) // [RL9]
      issue_i && dec_bus.op == HPM_OP_HW_S
      |=> target_register_o[31:0] == $past(prod_w[63:32]))
      else $error("high word result wrong");
   sign_flags_a: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i) // [RL6]
      condition_write_o && $past(dec_bus.op) == HPM_OP_HD_U
      |-> condition_field_zero_o[HPM_CF_NEG] == target_register_o[63])
      else $error("negative flag not from signed compare");
   legacy_split_a: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i) // [RL13]
      issue_i && dec_bus.op == HPM_OP_W_LEG
      |=> product_extension_register_o == $past(prod_w[31:0]))
      else $error("extension register not loaded with product");
   overflow_set_a: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i) // [RL12]
      issue_i && dec_bus.op == HPM_OP_W_LEG && dec_bus.oe_bit && word_over
      |=> exception_write_o && fixed_point_exception_register_o[31:30] == 2'h3)
      else $error("word overflow not flagged");
   xer_quiet_a: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i) // [RL16]
      issue_hi_any |=> !exception_write_o)
      else $error("high product wrote exception register");
endmodule
`default_nettype wire

// File: bench/hpm_issue_model.sv
// Issue pipeline model driving the multiply unit's request side
`timescale 1ns/1ps
`default_nettype none
module hpm_issue_model
(
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic req_i,
   input wire logic [31:0] req_instr_i,
   input wire logic [63:0] req_a_i,
   input wire logic [63:0] req_b_i,
   output logic issue_o,
   output logic [31:0] instr_o,
   output logic [63:0] a_o,
   output logic [63:0] b_o
);
   logic [63:0] noise_reg;
   // Idle operands keep moving so stale values cannot pass for results
   always_ff @(posedge clk_sys_i or negedge reset_n_i)
   begin
      if (!reset_n_i)
         noise_reg <= 64'h5a5a_0f0f_3c3c_9696;
      else
         noise_reg <= {noise_reg[62:0], ~noise_reg[63]};
   end
   assign issue_o = req_i;
   assign instr_o = req_i ? req_instr_i : ~req_instr_i;
   assign a_o = req_i ? req_a_i : noise_reg;
   assign b_o = req_i ? req_b_i : ~noise_reg;
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench of the high-product multiply unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import hpm_pkg::*;
   typedef struct packed {
      logic done, ill, cw, ew, ov, leg;
      logic [4:0] idx;
      logic [3:0] cf;
      logic [31:0] fixed_point_exception_register, ext;
      logic [63:0] tgt, msk;
   } hpm_exp_s;
   logic clk_sys_i, reset_n_i, req, is64, issue, done_o, illegal_o;
   logic target_write_o, condition_write_o, exception_write_o;
   logic [4:0] target_index_o;
   logic [3:0] condition_field_zero_o;
   logic [31:0] req_instr, instr, fixed_point_exception_register, fixed_point_exception_register_o;
   logic [31:0] product_extension_register_o;
   logic [63:0] req_a, req_b, op_a, op_b, target_register_o;
   hpm_exp_s pend;
   int failures, cmp_count, seed;

   hpm_issue_model i_hpm_issue_model (.clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i), .req_i(req), .req_instr_i(req_instr),
      .req_a_i(req_a), .req_b_i(req_b), .issue_o(issue), .instr_o(instr),
      .a_o(op_a), .b_o(op_b));
   hpm_unit i_hpm_unit (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
      .issue_i(issue), .instr_i(instr), .is_64bit_i(is64),
      .first_source_register_i(op_a), .second_source_register_i(op_b),
      .fixed_point_exception_register_i(fixed_point_exception_register), .done_o(done_o),
      .illegal_o(illegal_o), .target_index_o(target_index_o),
      .target_register_o(target_register_o),
      .target_write_o(target_write_o),
      .condition_field_zero_o(condition_field_zero_o),
      .condition_write_o(condition_write_o),
      .fixed_point_exception_register_o(fixed_point_exception_register_o),
      .exception_write_o(exception_write_o),
      .product_extension_register_o(product_extension_register_o));

   initial
   begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   task automatic finish_test;
      if (failures == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
      cmp_count++;
      if (g !== e)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   function automatic logic [63:0] rnd;
      return {$random(seed), $random(seed)};
   endfunction

   function automatic hpm_exp_s calc(input logic [2:0] k, input logic oe,
         input logic rc, input logic [63:0] a, input logic [63:0] b,
         input logic [31:0] x);
      hpm_exp_s e;
      logic [127:0] p;
      logic [63:0] r;
      e = '0;
      e.msk = {64{1'b1}};
      e.fixed_point_exception_register = x;
      if (k == 3'd0)
         p = $signed({{64{a[63]}}, a}) * $signed({{64{b[63]}}, b});
      else if (k == 3'd1)
         p = {64'h0, a} * {64'h0, b};
      else
         p = {64'h0, $signed({{32{a[31]}}, a[31:0]}) * $signed({{32{b[31]}}, b[31:0]})};
      r = (k == 3'd2) ? {{32{p[63]}}, p[63:32]} : p[127:64];
      e.done = (k == 3'd2) || (k == 3'd3) || (k <= 3'd1 && !oe && is64);
      e.ill = k <= 3'd1 && !oe && !is64;
      if (k == 3'd3)
      begin
         r = {32'h0, p[63:32]};
         e.msk = 64'h0000_0000_ffff_ffff;
         e.ext = p[31:0];
         e.leg = 1'b1;
         e.ew = oe;
         e.ov = oe && !(&p[63:31] || ~|p[63:31]);
         if (e.ov)
            e.fixed_point_exception_register = x | 32'hc000_0000;
      end
      e.tgt = r;
      e.cw = e.done && rc;
      if (k == 3'd3)
         r = {{32{p[31]}}, p[31:0]};
      e.cf = {r[63], !r[63] && r != 64'h0, r == 64'h0, e.fixed_point_exception_register[31]};
      return e;
   endfunction

   task automatic check_out(input hpm_exp_s e);
      chk("done", 64'(e.done), 64'(done_o));
      chk("illegal", 64'(e.ill), 64'(illegal_o));
      chk("target_write", 64'(e.done), 64'(target_write_o));
      chk("cond_write", 64'(e.cw), 64'(condition_write_o));
      chk("exc_write", 64'(e.ew), 64'(exception_write_o));
      if (e.done)
      begin
         chk("target", e.tgt, target_register_o & e.msk);
         chk("index", 64'(e.idx), 64'(target_index_o));
      end
      if (e.cw)
         chk("cond", 64'(e.cf), 64'(condition_field_zero_o));
      if (e.ew)
         chk("exc", 64'(e.fixed_point_exception_register), 64'(fixed_point_exception_register_o));
      if (e.leg && e.done)
         chk("ext", 64'(e.ext), 64'(product_extension_register_o));
   endtask

   task automatic step(input logic v, input logic [2:0] k, input logic oe,
         input logic rc, input logic [63:0] a, input logic [63:0] b,
         input logic [31:0] x);
      logic [8:0] xo;
      logic [14:0] regs;
      @(posedge clk_sys_i);
      #1;
      check_out(pend);
      regs = 15'($random(seed));
      case (k)
         3'd1: xo = HPM_XOP_HI_DWORD_U;
         3'd2: xo = HPM_XOP_HI_WORD_S;
         3'd3: xo = HPM_XOP_WORD_LEGACY;
         3'd4: xo = 9'h0e9;
         default: xo = HPM_XOP_HI_DWORD_S;
      endcase
      req = v;
      req_instr = {(k == 3'd5) ? 6'h1e : HPM_PRIMARY_OP, regs, oe, xo, rc};
      req_a = a;
      req_b = b;
      fixed_point_exception_register = x;
      pend = calc(k, oe, rc, a, b, x);
      pend.idx = regs[14:10];
      if (!v)
         pend = '0;
   endtask

   initial
   begin
      #100000;
      failures++;
      finish_test();
   end

   initial
   begin
      seed = 21474;
      failures = 0;
      cmp_count = 0;
      reset_n_i = 1'b0;
      req = 1'b0;
      is64 = 1'b1;
      req_instr = '0;
      req_a = '0;
      req_b = '0;
      fixed_point_exception_register = '0;
      pend = '0;
      repeat (6) @(posedge clk_sys_i);
      #1;
      reset_n_i = 1'b1;
      step(1'b1, 3'd3, 1'b0, 1'b1, 64'h4500, 64'h8000_7000, 32'h0);
      step(1'b1, 3'd3, 1'b1, 1'b1, 64'h4500, 64'h8000_7000, 32'h0);
      step(1'b1, 3'd3, 1'b1, 1'b0, 64'h3, 64'h2, 32'h0);
      step(1'b1, 3'd2, 1'b0, 1'b1, 64'h4500, 64'h8000_7000, 32'h0);
      // Every form with each bit-21 and record combination
      for (int k = 0; k < 6; k++)
         for (int m = 0; m < 8; m++)
            step(1'b1, 3'(k), m[1], m[0], m[2] ? 64'h8000_0000_8000_0000 : rnd(),
               m[2] ? {64{1'b1}} : rnd(), {m[0], 31'($random(seed))});
      is64 = 1'b0;
      for (int m = 0; m < 16; m++)
         step(1'b1, 3'(m % 4), m[2], m[3], rnd(), rnd(), 32'($random(seed)));
      is64 = 1'b1;
      for (int i = 0; i < 400; i++)
         step(|2'($random(seed)), 3'(($random(seed) & 32'h7fff_ffff) % 6),
            1'($random(seed)), 1'($random(seed)), rnd(), rnd(),
            32'($random(seed)));
      step(1'b0, 3'd0, 1'b0, 1'b0, 64'h0, 64'h0, 32'h0);
      step(1'b0, 3'd0, 1'b0, 1'b0, 64'h0, 64'h0, 32'h0);
      finish_test();
   end
endmodule
`default_nettype wire
